// >>> gpio_port_consts.svh
// Constants for the bidirectional port with external interrupt groups
`ifndef GPIO_PORT_CONSTS_SVH
`define GPIO_PORT_CONSTS_SVH

// ==========================================================
// Port geometry
`define PORT_PINS 8
`define GROUP_PINS 4
`define IRQ_GROUPS 2
`define GROUP0_LSB 0
`define GROUP1_LSB 4

// ==========================================================
// Reset values
`define BYTE_RST 8'h00
`define SENSE_RST 2'b00
`define INVERT_RST 1'b0
`define GROUP_RST 2'b00

`endif

// >>> gpio_port_pkg.sv
// Types shared by the port and its interrupt detectors
package gpio_port_pkg;

  // Group sensitivity codes
  typedef enum logic [1:0] {
    SENSE_FALL_LOW = 2'b00,
    SENSE_RISE = 2'b01,
    SENSE_FALL = 2'b10,
    SENSE_BOTH = 2'b11
  } sense_type;

  // Pin mode as {direction, option}
  typedef enum logic [1:0] {
    MODE_IN_FLOAT = 2'b00,
    MODE_IN_IRQ = 2'b01,
    MODE_OUT_OD = 2'b10,
    MODE_OUT_PP = 2'b11
  } pin_mode_type;

endpackage

// >>> ext_irq_detect.sv
// Event detector for one group of interrupt-capable pins
module ext_irq_detect
  import gpio_port_pkg::*;
#(
  parameter int WIDTH = 4
) (
  input wire logic [WIDTH-1:0] level_i,
  input wire logic [WIDTH-1:0] prev_i,
  input wire logic [WIDTH-1:0] en_i,
  input wire sense_type sense_i,
  input wire logic invert_i,
  output wire logic hit_o
);

  // ==========================================================
  // Polarity inversion turns falling into rising, low into high
  wire logic [WIDTH-1:0] cur;
  wire logic [WIDTH-1:0] old;
  assign cur = invert_i ? ~level_i : level_i;
  assign old = invert_i ? ~prev_i : prev_i;

  // Per-pin edge and level terms
  wire logic [WIDTH-1:0] rise;
  wire logic [WIDTH-1:0] fall;
  wire logic [WIDTH-1:0] low;
  assign rise = cur & ~old;
  assign fall = ~cur & old;
  assign low = ~cur;

  // ==========================================================
  // Detect each pin by the group sensitivity, then OR them
  wire logic [WIDTH-1:0] det;
  assign det = (sense_i == SENSE_FALL_LOW) ? low :
               (sense_i == SENSE_RISE) ? rise :
               (sense_i == SENSE_FALL) ? fall :
               (rise | fall); // R9
  assign hit_o = |(det & en_i); // R9

endmodule

// >>> gpio_port.sv
// Eight-pin bidirectional port with alternate functions and interrupts
//
// Contract
// [R1] Eight pins, bit X controls pin X
// [R2] Input pin: data read returns pin level
// [R3] Input pin: data write only updates latch
// [R4] Output pin: driven from latch, read returns latch
// [R5] Option selects push-pull or open-drain output
// [R6] Option selects input variant: floating or pull-up
// [R7] Mode {direction, option}: 00,01,10,11 encoding
// [R8] Interrupt input raises request using group sensitivity
// [R9] Group pins detected separately then ORed
// [R10] Request latch clears on vector fetch
// [R11] Sensitivity write discards pending group request
// [R12] Request passed only if configured and unmasked
// [R13] Peripheral claim overrides direction and option
// [R14] Peripheral output forces output mode, its type
// [R15] Peripheral input: keep input mode, read pin
// [R16] Input pin with peripheral output: read peripheral
// [R17] Output pin with peripheral input: peripheral gets latch
// [R18] No alternate function on interrupt input pins
// [R19] Load latch before switching pin to output
// [R20] Avoid bit set/clear on data latch
// [R21] Shared in/out peripheral pin uses floating input
// [R22] Interrupt pin inputs pass two sync stages
module gpio_port
  import gpio_port_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  // Core register writes and read-back
  input wire logic [7:0] wdata_i,
  input wire logic data_wr_i,
  input wire logic dir_wr_i,
  input wire logic opt_wr_i,
  output logic [7:0] data_rd_o,
  output logic [7:0] dir_o,
  output logic [7:0] opt_o,
  // External interrupt sensitivity and core state
  input wire logic [1:0] ext_irq_sense_wr_i,
  input wire logic [1:0] ext_irq_sense_i,
  input wire logic ext_irq_invert_i,
  input wire logic core_level3_i,
  input wire logic core_irq_mask_i,
  input wire logic [1:0] vec_fetch_i,
  output logic [1:0] irq_req_o,
  // Peripheral alternate functions
  input wire logic [7:0] alt_en_i,
  input wire logic [7:0] alt_drive_i,
  input wire logic [7:0] alt_od_i,
  input wire logic [7:0] alt_out_i,
  output logic [7:0] alt_in_o,
  // Package pins
  input wire logic [7:0] pin_i,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe_o,
  output logic [7:0] pull_en_o
);

`include "gpio_port_consts.svh"

  // ==========================================================
  // Registers
  logic [7:0] pin_data_latch_reg;
  logic [7:0] dir_reg;
  logic [7:0] opt_reg;
  logic [7:0] pin_meta_reg;
  logic [7:0] pin_sync_reg;
  logic [7:0] pin_prev_reg;
  sense_type sense_reg [`IRQ_GROUPS];
  logic [1:0] invert_reg;
  logic [1:0] pend_reg;
  logic [1:0] pend_next;

  // ==========================================================
  // Per-pin mode decode
  wire logic [7:0] alt_drive;
  wire logic [7:0] out_mode;
  wire logic [7:0] drive_val;
  wire logic [7:0] drive_od;
  wire logic [7:0] oe_next;
  wire logic [7:0] rd_next;
  wire logic [7:0] alt_in_next;
  wire logic [7:0] pull_next;
  wire logic [7:0] irq_pin_en;

  // Peripheral drives only pins it has claimed
  assign alt_drive = alt_en_i & alt_drive_i; // R13
  // Output when direction set or peripheral drives
  assign out_mode = dir_reg | alt_drive; // R4 R14
  // Value from peripheral when it drives, else latch
  assign drive_val = (alt_drive & alt_out_i) |
                     (~alt_drive & pin_data_latch_reg); // R13
  // Open-drain from peripheral choice, else option clear
  assign drive_od = (alt_drive & alt_od_i) |
                    (~alt_drive & ~opt_reg); // R5 R14
  // Open-drain enables only for a low level
  assign oe_next = out_mode & (~drive_od | ~drive_val); // R5
  // Pull-up on input pins with option set
  assign pull_next = ~out_mode & opt_reg; // R6 R7
  // Read source per pin
  assign rd_next = (~dir_reg & alt_drive & alt_out_i) |
                   (dir_reg & pin_data_latch_reg) |
                   (~dir_reg & ~alt_drive & pin_sync_reg); // R2 R4 R15 R16
  // Peripheral input sees latch on output pins
  assign alt_in_next = (dir_reg & pin_data_latch_reg) |
                       (~dir_reg & pin_sync_reg); // R15 R17
  // Interrupt input is mode 01 without alternate claim
  assign irq_pin_en = ~dir_reg & opt_reg & ~alt_en_i; // R7 R8 R12

  // ==========================================================
  // Data latch, direction and option registers
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_data_latch_reg <= `BYTE_RST;
      dir_reg <= `BYTE_RST;
      opt_reg <= `BYTE_RST;
    end else begin
      if (data_wr_i) begin
        pin_data_latch_reg <= wdata_i; // R3
      end
      if (dir_wr_i) begin
        dir_reg <= wdata_i; // R1
      end
      if (opt_wr_i) begin
        opt_reg <= wdata_i; // R1
      end
    end
  end

  // ==========================================================
  // Two-stage pin synchroniser plus previous sample
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_meta_reg <= `BYTE_RST;
      pin_sync_reg <= `BYTE_RST;
      pin_prev_reg <= `BYTE_RST;
    end else begin
      pin_meta_reg <= pin_i; // R22
      pin_sync_reg <= pin_meta_reg; // R22
      pin_prev_reg <= pin_sync_reg;
    end
  end

  // ==========================================================
  // Registered pin, read and peripheral outputs
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_o <= `BYTE_RST;
      pin_oe_o <= `BYTE_RST;
      pull_en_o <= `BYTE_RST;
      data_rd_o <= `BYTE_RST;
      alt_in_o <= `BYTE_RST;
      dir_o <= `BYTE_RST;
      opt_o <= `BYTE_RST;
    end else begin
      pin_o <= drive_val & ~drive_od; // R5
      pin_oe_o <= oe_next; // R5
      pull_en_o <= pull_next; // R6
      data_rd_o <= rd_next; // R2 R4
      alt_in_o <= alt_in_next; // R17
      dir_o <= dir_reg;
      opt_o <= opt_reg;
    end
  end

  // ==========================================================
  // Sensitivity registers, written only at core level 3
  wire logic [1:0] sense_wr_ok;
  assign sense_wr_ok = ext_irq_sense_wr_i & {2{core_level3_i}};

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sense_reg[0] <= SENSE_FALL_LOW;
      sense_reg[1] <= SENSE_FALL_LOW;
      invert_reg <= `GROUP_RST;
    end else begin
      for (int g = 0; g < `IRQ_GROUPS; g++) begin
        if (sense_wr_ok[g]) begin
          sense_reg[g] <= sense_type'(ext_irq_sense_i);
          invert_reg[g] <= ext_irq_invert_i;
        end
      end
    end
  end

  // ==========================================================
  // Group event detectors
  wire logic [1:0] hit;

  ext_irq_detect #(.WIDTH(`GROUP_PINS)) u_det_lo (
    .level_i(pin_sync_reg[3:0]),
    .prev_i(pin_prev_reg[3:0]),
    .en_i(irq_pin_en[3:0]),
    .sense_i(sense_reg[0]),
    .invert_i(invert_reg[0]),
    .hit_o(hit[0])
  ); // R8 R9

  ext_irq_detect #(.WIDTH(`GROUP_PINS)) u_det_hi (
    .level_i(pin_sync_reg[7:4]),
    .prev_i(pin_prev_reg[7:4]),
    .en_i(irq_pin_en[7:4]),
    .sense_i(sense_reg[1]),
    .invert_i(invert_reg[1]),
    .hit_o(hit[1])
  ); // R8 R9

  // ==========================================================
  // Hidden request latches: new event beats fetch clear,
  // sensitivity write discards its group's request and event
  assign pend_next = ~sense_wr_ok &
                     (hit | (pend_reg & ~vec_fetch_i)); // R10 R11

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pend_reg <= `GROUP_RST;
      irq_req_o <= `GROUP_RST;
    end else begin
      pend_reg <= pend_next;
      irq_req_o <= pend_next & {2{~core_irq_mask_i}}; // R12
    end
  end

  // ==========================================================
  // Checks
  chk_sync_depth: assert property ( // R22
    @(posedge clk_i) disable iff (!rstn_i)
    $past(rstn_i, 2) |-> pin_sync_reg == $past(pin_i, 2))
    else $error("pin sync depth wrong");

  chk_write_latch: assert property ( // R3
    @(posedge clk_i) disable iff (!rstn_i)
    data_wr_i |=> pin_data_latch_reg == $past(wdata_i))
    else $error("data latch not written");

  chk_input_undriven: assert property ( // R3
    @(posedge clk_i) disable iff (!rstn_i)
    ((~$past(dir_reg) & ~$past(alt_drive)) & pin_oe_o) == 8'h00)
    else $error("input pin driven");

  chk_read_input: assert property ( // R2
    @(posedge clk_i) disable iff (!rstn_i)
    ((~$past(dir_reg) & ~$past(alt_drive)) &
     (data_rd_o ^ $past(pin_sync_reg))) == 8'h00)
    else $error("input read not pin level");

  chk_read_output: assert property ( // R4
    @(posedge clk_i) disable iff (!rstn_i)
    ($past(dir_reg) &
     (data_rd_o ^ $past(pin_data_latch_reg))) == 8'h00)
    else $error("output read not latch");

  chk_open_drain: assert property ( // R5
    @(posedge clk_i) disable iff (!rstn_i)
    ($past(dir_reg & ~opt_reg & ~alt_drive) &
     ((pin_oe_o ^ ~$past(pin_data_latch_reg)) | pin_o)) == 8'h00)
    else $error("open-drain drive wrong");

  chk_push_pull: assert property ( // R5
    @(posedge clk_i) disable iff (!rstn_i)
    ($past(dir_reg & opt_reg & ~alt_drive) &
     (~pin_oe_o | (pin_o ^ $past(pin_data_latch_reg)))) == 8'h00)
    else $error("push-pull drive wrong");

  chk_alt_forces_out: assert property ( // R14
    @(posedge clk_i) disable iff (!rstn_i)
    ($past(alt_drive & ~alt_od_i) &
     (~pin_oe_o | (pin_o ^ $past(alt_out_i)))) == 8'h00)
    else $error("peripheral output not driven");

  chk_alt_read: assert property ( // R16
    @(posedge clk_i) disable iff (!rstn_i)
    ($past(~dir_reg & alt_drive) &
     (data_rd_o ^ $past(alt_out_i))) == 8'h00)
    else $error("read not peripheral output");

  chk_alt_in_latch: assert property ( // R17
    @(posedge clk_i) disable iff (!rstn_i)
    ($past(dir_reg) &
     (alt_in_o ^ $past(pin_data_latch_reg))) == 8'h00)
    else $error("peripheral input not latch");

  chk_event_sets: assert property ( // R9
    @(posedge clk_i) disable iff (!rstn_i)
    (hit[0] && !sense_wr_ok[0]) |=> pend_reg[0])
    else $error("group event lost");

  chk_fetch_clears: assert property ( // R10
    @(posedge clk_i) disable iff (!rstn_i)
    (vec_fetch_i[1] && !hit[1]) |=> !pend_reg[1])
    else $error("fetch did not clear request");

  chk_sense_discard: assert property ( // R11
    @(posedge clk_i) disable iff (!rstn_i)
    sense_wr_ok[0] |=> !pend_reg[0] && !irq_req_o[0])
    else $error("sense write kept request");

  chk_mask_blocks: assert property ( // R12
    @(posedge clk_i) disable iff (!rstn_i)
    core_irq_mask_i |=> irq_req_o == 2'b00)
    else $error("masked request passed");

  chk_config_gate: assert property ( // R12
    @(posedge clk_i) disable iff (!rstn_i)
    (irq_pin_en[3:0] == 4'h0 && !pend_reg[0]) |=> !pend_reg[0])
    else $error("request from non-irq pin");

endmodule

// >>> gpio_pin_model.sv
// Pad model: device drive, external drive, pull-up or floating
module gpio_pin_model (
  input wire logic clk_i,
  input wire logic [7:0] drv_i,
  input wire logic [7:0] oe_i,
  input wire logic [7:0] pull_i,
  input wire logic [7:0] ext_en_i,
  input wire logic [7:0] ext_val_i,
  output logic [7:0] pad_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] float_reg = 8'h00;
  // Undriven pads with no pull wander every cycle
  always @(posedge clk_i) float_reg <= ~float_reg;
  // Pad level, device drive first
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (oe_i[i]) pad_o[i] = drv_i[i];
      else if (ext_en_i[i]) pad_o[i] = ext_val_i[i];
      else if (pull_i[i]) pad_o[i] = 1'b1;
      else pad_o[i] = float_reg[i];
    end
  end
endmodule

// >>> test_gpio_port.sv
// Self-checking bench for the eight-pin port
module test_gpio_port;
  import gpio_port_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic data_wr = 1'b0, dir_wr = 1'b0, opt_wr = 1'b0, lvl3 = 1'b0;
  logic mask = 1'b0, invert = 1'b0;
  logic [1:0] sense_wr = 2'h0, sense = 2'h0, fetch = 2'h0, irq;
  logic [7:0] wdata = 8'h00, alt_en = 8'h00, alt_drive = 8'h00;
  logic [7:0] alt_od = 8'h00, alt_out = 8'h00, ext_en = 8'h00;
  logic [7:0] ext_val = 8'h00, data_rd, dir, opt, alt_in;
  logic [7:0] pin_in, pin_out, pin_oe, pull_en;
  int mismatches = 0;
  int n_checks = 0;

  // ==========================================================
  // Clock, design and pads
  always #12.5 clk_i = ~clk_i;
  gpio_port gpio_port_inst (.clk_i(clk_i), .rstn_i(rstn_i),
    .wdata_i(wdata), .data_wr_i(data_wr), .dir_wr_i(dir_wr),
    .opt_wr_i(opt_wr), .data_rd_o(data_rd), .dir_o(dir), .opt_o(opt),
    .ext_irq_sense_wr_i(sense_wr), .ext_irq_sense_i(sense),
    .ext_irq_invert_i(invert), .core_level3_i(lvl3),
    .core_irq_mask_i(mask), .vec_fetch_i(fetch), .irq_req_o(irq),
    .alt_en_i(alt_en), .alt_drive_i(alt_drive), .alt_od_i(alt_od),
    .alt_out_i(alt_out), .alt_in_o(alt_in), .pin_i(pin_in),
    .pin_o(pin_out), .pin_oe_o(pin_oe), .pull_en_o(pull_en));
  gpio_pin_model gpio_pin_model_inst (.clk_i(clk_i), .drv_i(pin_out),
    .oe_i(pin_oe), .pull_i(pull_en), .ext_en_i(ext_en),
    .ext_val_i(ext_val), .pad_o(pin_in));

  // ==========================================================
  // Access tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Let registered and synchronised outputs land
  task automatic settle;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  // Whole-byte write: 0 data, 1 direction, 2 option
  task automatic wr(input int sel, input logic [7:0] v);
    @(posedge clk_i);
    wdata <= v;
    data_wr <= (sel == 0);
    dir_wr <= (sel == 1);
    opt_wr <= (sel == 2);
    @(posedge clk_i);
    data_wr <= 1'b0;
    dir_wr <= 1'b0;
    opt_wr <= 1'b0;
    settle;
  endtask
  task automatic sense_set(input logic [1:0] code);
    @(posedge clk_i);
    sense <= code;
    sense_wr <= 2'b11;
    @(posedge clk_i);
    sense_wr <= 2'b00;
    settle;
  endtask
  task automatic ext(input logic [7:0] en, input logic [7:0] v);
    @(posedge clk_i);
    ext_en <= en;
    ext_val <= v;
    settle;
  endtask
  task automatic alt(input logic [7:0] e, d, od, o);
    @(posedge clk_i);
    alt_en <= e;
    alt_drive <= d;
    alt_od <= od;
    alt_out <= o;
    settle;
  endtask
  task automatic fetch_vec(input logic [1:0] g);
    @(posedge clk_i);
    fetch <= g;
    @(posedge clk_i);
    fetch <= 2'b00;
    settle;
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    settle;
    check(dir, 8'h00);
    check(pin_oe, 8'h00);
    check(pull_en, 8'h00);
    // Input pins read the pads; writes only touch the latch
    ext(8'hff, 8'h5a);
    check(data_rd, 8'h5a);
    wr(0, 8'ha5);
    check(data_rd, 8'h5a);
    check(pin_oe, 8'h00);
    // Latch loaded first, then push-pull output
    ext(8'h00, 8'h00);
    wr(2, 8'hff);
    wr(1, 8'hff);
    check(opt, 8'hff);
    check(pin_oe, 8'hff);
    check(pin_out, 8'ha5);
    check(data_rd, 8'ha5);
    // Open-drain drives only the zero bits
    wr(2, 8'h00);
    check(pin_oe, 8'h5a);
    check(pin_out, 8'h00);
    check(data_rd, 8'ha5);
    // Input with option set enables the pull-up
    wr(1, 8'h00);
    wr(2, 8'h0f);
    check(pull_en, 8'h0f);
    check(pin_oe, 8'h00);
    // Falling-edge interrupts, per group
    wr(2, 8'hff);
    @(posedge clk_i);
    lvl3 <= 1'b1;
    sense_set(2'b10);
    check({6'h00, irq}, 8'h00);
    ext(8'h02, 8'h00);
    check({6'h00, irq}, 8'h01);
    fetch_vec(2'b01);
    check({6'h00, irq}, 8'h00);
    ext(8'h62, 8'h00);
    check({6'h00, irq}, 8'h02);
    sense_set(2'b10);
    check({6'h00, irq}, 8'h00);
    // Masked core sees no request
    @(posedge clk_i);
    mask <= 1'b1;
    sense_set(2'b01);
    ext(8'h00, 8'h00);
    check({6'h00, irq}, 8'h00);
    sense_set(2'b01);
    @(posedge clk_i);
    mask <= 1'b0;
    // Both edges, then level modes with and without inversion
    sense_set(2'b11);
    ext(8'h10, 8'h00);
    check({6'h00, irq}, 8'h02);
    fetch_vec(2'b10);
    check({6'h00, irq}, 8'h00);
    ext(8'h00, 8'h00);
    check({6'h00, irq}, 8'h02);
    sense_set(2'b00);
    check({6'h00, irq}, 8'h00);
    @(posedge clk_i);
    invert <= 1'b1;
    sense_set(2'b00);
    check({6'h00, irq}, 8'h03);
    fetch_vec(2'b11);
    check({6'h00, irq}, 8'h03);
    @(posedge clk_i);
    invert <= 1'b0;
    sense_set(2'b01);
    check({6'h00, irq}, 8'h00);
    // Alternate functions on floating inputs only
    wr(2, 8'h00);
    alt(8'h01, 8'h01, 8'h00, 8'h01);
    check(pin_oe & 8'h01, 8'h01);
    check(pin_out & 8'h01, 8'h01);
    check(data_rd & 8'h01, 8'h01);
    alt(8'h01, 8'h01, 8'h01, 8'h00);
    check(pin_oe & 8'h01, 8'h01);
    check(pin_out & 8'h01, 8'h00);
    // Peripheral input takes the latch on an output pin
    alt(8'h05, 8'h01, 8'h00, 8'h01);
    wr(0, 8'h04);
    wr(1, 8'h04);
    check(alt_in & 8'h04, 8'h04);
    check(pin_oe & 8'h05, 8'h01);
    check(data_rd & 8'h05, 8'h05);
    wr(1, 8'h00);
    ext(8'h04, 8'h00);
    check(alt_in & 8'h04, 8'h00);
    check(data_rd & 8'h04, 8'h00);
    finish_test;
  end
endmodule
